// >>> logic/prom_programming_port.sv
`timescale 1ns/1ps
// Overview of operation
// - reset low plus mode pin high enters mode
// - ports zero/one address, two data, three strobes
// - both strobes low drive addressed byte out
// - output gate high floats the data lines
// - program behaviour only with programming voltage present
// - chip select low with output gate high starts byte store
// - top address bit forced high in mode
module prom_programming_port #(
  parameter int MEM_DEPTH = 1 << prom_port_pkg::ADDR_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reset_pin_n_i,
  input wire logic prog_voltage_mode_pin_i,
  input wire logic vpp_high_i,
  input wire logic [7:0] addr_low_port_i,
  input wire logic [6:0] addr_high_port_i,
  input wire logic [prom_port_pkg::DATA_W-1:0] data_byte_port_i,
  input wire logic chip_sel_n_i,
  input wire logic out_gate_n_i,
  output logic [prom_port_pkg::DATA_W-1:0] data_byte_port_o,
  output logic data_byte_port_oe_o,
  output logic prog_mode_o,
  output logic [prom_port_pkg::FULL_ADDR_W-1:0] mem_address_o,
  output logic write_strobe_o,
  output logic [prom_port_pkg::DATA_W-1:0] write_data_o
);
  import prom_port_pkg::*;

  // registered pins plus the one-store-per-phase flag
  port_state_t st;
  port_state_t next_st;

  // strobes and levels as the programmer presents them
  ctrl_t ctrl;
  mode_t mode;

  // the one-time-programmable array
  logic [DATA_W-1:0] mem [MEM_DEPTH];

  // fifteen-bit address assembled from the two address ports
  logic [ADDR_W-1:0] memory_address_lines;
  logic [DATA_W-1:0] rd_byte;

  // a smaller array leaves the upper addresses unbacked
  logic addr_in_range;
  logic store_in_range;

  // cell contents before and after a store
  logic [DATA_W-1:0] cell_byte;
  wire logic [DATA_W-1:0] prog_byte;

  // byte to show next: the array on a read or verify, else the held byte
  wire logic [DATA_W-1:0] next_dout;

  // qualifiers for the mode decode
  logic in_mode;
  logic vpp_present;
  logic cs_active;
  logic gate_active;
  logic store_start;
  logic drive_data;

  assign ctrl = {
    reset_pin_n_i,
    prog_voltage_mode_pin_i,
    vpp_high_i,
    chip_sel_n_i,
    out_gate_n_i
  };

  assign in_mode = !ctrl.reset_n && ctrl.prog_voltage_mode_pin;
  assign vpp_present = ctrl.vpp_high;
  assign cs_active = !ctrl.chip_sel_n;
  assign gate_active = !ctrl.out_gate_n;

  assign memory_address_lines = {addr_high_port_i, addr_low_port_i};
  assign addr_in_range = (32'(memory_address_lines) < MEM_DEPTH);
  assign store_in_range = (32'(st.mem_addr[ADDR_W-1:0]) < MEM_DEPTH);

  // unbacked addresses read as an erased cell
  assign rd_byte = addr_in_range ? mem[memory_address_lines] : ERASED_BYTE;
  assign cell_byte = store_in_range ? mem[st.mem_addr[ADDR_W-1:0]] : ERASED_BYTE;

  // a store can only clear bits, as on a one-time-programmable cell
  for (genvar b = 0; b < DATA_W; b++) begin : g_byte_bit
    assign prog_byte[b] = cell_byte[b] & st.wdata[b];
    assign next_dout[b] = drive_data ? rd_byte[b] : st.dout[b];
  end

  // decode of the five sub-modes
  always_comb begin
    mode = ST_IDLE;
    if (!in_mode) begin
      mode = ST_IDLE;
    end else if (!gate_active) begin
      if (vpp_present && cs_active) begin
        mode = ST_WRITE;
      end else begin
        mode = ST_DISABLE;
      end
    end else if (vpp_present && !cs_active) begin
      mode = ST_VERIFY;
    end else if (cs_active) begin
      mode = ST_READ;
    end else begin
      mode = ST_DISABLE;
    end
  end

  // only the first cycle of a chip-select-low phase may store, so a
  // programmer that holds chip select low for long still writes once
  assign store_start = (mode == ST_WRITE) && !st.store_done;
  assign drive_data = (mode == ST_READ) || (mode == ST_VERIFY);

  always_comb begin
    next_st = st;
    next_st.prog_mode = in_mode;
    next_st.mem_addr = {TOP_BIT_VALUE, memory_address_lines};
    next_st.write_strobe = 1'b0;
    next_st.store_done = 1'b0;
    next_st.dout_en = drive_data;
    case (mode)
      ST_READ: begin
        next_st.dout = next_dout;
        next_st.dout_en = 1'b1;
        next_st.write_strobe = 1'b0;
        next_st.store_done = 1'b0;
      end
      ST_VERIFY: begin
        next_st.dout = next_dout;
        next_st.dout_en = 1'b1;
        next_st.write_strobe = 1'b0;
        next_st.store_done = 1'b0;
      end
      ST_WRITE: begin
        // data lines are inputs here, so the output stays off
        next_st.dout_en = 1'b0;
        next_st.write_strobe = store_start;
        next_st.store_done = 1'b1;
        if (store_start) begin
          // byte held for the store that lands one cycle later
          next_st.wdata = data_byte_port_i;
        end
      end
      ST_DISABLE: begin
        next_st.dout_en = 1'b0;
        next_st.write_strobe = 1'b0;
        next_st.store_done = 1'b0;
      end
      ST_IDLE: begin
        // outside the mode the pins belong to the processor again
        next_st.dout_en = 1'b0;
        next_st.write_strobe = 1'b0;
        next_st.store_done = 1'b0;
      end
      default: begin
        next_st.dout_en = 1'b0;
        next_st.write_strobe = 1'b0;
        next_st.store_done = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st.dout <= '0;
      st.dout_en <= 1'b0;
      st.mem_addr <= '0;
      st.prog_mode <= 1'b0;
      st.write_strobe <= 1'b0;
      st.wdata <= '0;
      st.store_done <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // the array has no reset, like a real cell field; stores outside
  // a shortened array are dropped
  always_ff @(posedge clk_i) begin
    if (st.write_strobe && store_in_range) begin
      mem[st.mem_addr[ADDR_W-1:0]] <= prog_byte;
    end
  end

  // every output is a field of the state register

  assign data_byte_port_o = st.dout;
  assign data_byte_port_oe_o = st.dout_en;
  assign prog_mode_o = st.prog_mode;
  assign mem_address_o = st.mem_addr;
  assign write_strobe_o = st.write_strobe;
  assign write_data_o = st.wdata;
endmodule

// >>> logic/prom_port_pkg.sv
package prom_port_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int FULL_ADDR_W = 16;
  localparam int TOP_BIT_POS = 15;
  localparam logic TOP_BIT_VALUE = 1'b1;
  localparam int PROG_CYCLES_DEFAULT = 4;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  typedef enum {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_VERIFY,
    ST_DISABLE
  } mode_t;

  // strobes and levels seen from the programmer
  typedef struct packed {
    logic reset_n;
    logic prog_voltage_mode_pin;
    logic vpp_high;
    logic chip_sel_n;
    logic out_gate_n;
  } ctrl_t;

  typedef struct packed {
    logic [7:0] dout;
    logic dout_en;
    logic [15:0] mem_addr;
    logic prog_mode;
    logic write_strobe;
    logic [7:0] wdata;
    logic store_done;
  } port_state_t;
endpackage

// >>> bench/prom_port_assertions.sv
`timescale 1ns/1ps
module prom_port_assertions(
  input wire logic clk_i,rst_n_i,reset_pin_n_i,prog_voltage_mode_pin_i,vpp_high_i,
  input wire logic chip_sel_n_i,out_gate_n_i,data_byte_port_oe_o,prog_mode_o,write_strobe_o,
  input wire logic [15:0] mem_address_o);
  wire r=rst_n_i,c=chip_sel_n_i,g=out_gate_n_i,v=vpp_high_i,e=data_byte_port_oe_o;
  wire w=write_strobe_o,m=!reset_pin_n_i&&prog_voltage_mode_pin_i,p=m&&v,pg=p&&g;
  wire rd=r&&m&&!c&&!g&&!v,wr=r&&pg&&!c,vf=r&&p&&c&&!g,rm=r&&m,cr=c&&r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!r);
  a_mode_flag: assert property ($past(r)|->prog_mode_o==$past(m)) else $error("mode");
  a_read_out: assert property ($past(rd)|->e) else $error("read");
  a_gate_off: assert property ($past(g)|->!e) else $error("gate");
  a_store_ok: assert property (w|->$past(pg)) else $error("vpp");
  a_store_go: assert property ($past(wr)&&$past(cr,2)|->w) else $error("go");
  a_one_pulse: assert property (w|=>!w) else $error("pulse");
  a_top_bit: assert property ($past(rm)|->mem_address_o[15]) else $error("top");
  a_verify_out: assert property ($past(vf)|->e) else $error("verify");
endmodule
bind prom_programming_port prom_port_assertions u_chk(.*);

// >>> bench/programmer_model.sv
`timescale 1ns/1ps
module programmer_model(
  input wire logic data_byte_port_oe_o,
  input wire logic [7:0] data_byte_port_o,drv,
  output logic [7:0] data_byte_port_i);
  assign data_byte_port_i=data_byte_port_oe_o?data_byte_port_o:drv;
endmodule

// >>> bench/prom_programming_port_test.sv
`timescale 1ns/1ps
module prom_programming_port_test;
  logic clk_i=0,rst_n_i=0,reset_pin_n_i=1,prog_voltage_mode_pin_i=0,vpp_high_i=0;
  logic chip_sel_n_i=1,out_gate_n_i=1,data_byte_port_oe_o,prog_mode_o,write_strobe_o;
  logic [7:0] addr_low_port_i=8'hff,drv=0,data_byte_port_i,data_byte_port_o,write_data_o;
  logic [6:0] addr_high_port_i=7'h7f;
  logic [15:0] mem_address_o;
  int n_fail=0,num_checks=0,seed=11012,cyc=0,n_store=0;
  always @(negedge clk_i) n_store+=write_strobe_o;
  always #2.5 clk_i=~clk_i;
  always @(posedge clk_i) if(++cyc>999) results(1);
  prom_programming_port u_dut(.*);
  programmer_model u_prog(.*);
  task chk(string s,logic [15:0] g,x);
    num_checks++;
    if(g!==x) $display("Error %s exp %h got %h",s,x,g);
    n_fail+=g!==x;
  endtask
  task step(logic [2:0] s);
    {chip_sel_n_i,out_gate_n_i,vpp_high_i}=s;
    repeat(2) @(posedge clk_i);
    #1;
  endtask
  task results(int t);
    n_fail+=t;
    $display("%0d fails %0d checks",n_fail,num_checks);
    if(n_fail==0&&num_checks>0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat(3) @(posedge clk_i);
    #1;
    rst_n_i=1;
    {reset_pin_n_i,prog_voltage_mode_pin_i}=2'h1;
    for(int i=0;i<8;i++) begin
      drv=8'($random(seed));
      step(3'h7);
      step(3'h3);
      chk("addr",mem_address_o,{1'b1,addr_high_port_i,addr_low_port_i});
      chk("wdata",write_data_o,drv);
      chk("store",16'(n_store),16'(i+1));
      chk("float",data_byte_port_oe_o,1'b0);
      chk("mode",prog_mode_o,1'b1);
      step(3'h5);
      chk("verify",data_byte_port_o|drv,drv);
      chk("drive",data_byte_port_oe_o,1'b1);
      step(3'h0);
      chk("read",data_byte_port_o|drv,drv);
      {addr_high_port_i,addr_low_port_i}=15'($random(seed));
    end
    step(3'h2);
    chk("no_vpp",16'(n_store),16'd8);
    chk("float2",data_byte_port_oe_o,1'b0);
    reset_pin_n_i=1;
    step(3'h0);
    chk("exit",prog_mode_o,1'b0);
    chk("idle_oe",data_byte_port_oe_o,1'b0);
    results(0);
  end
endmodule
